// File: rtl/rcvk_pkg.sv
// Package: register map, field layout and reset values of the RC trim and vcore block
package rcvk_pkg;
   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [11:0] OFS_CTL   = 12'h034;
   localparam logic [11:0] OFS_KEY   = 12'h100;
   localparam logic [11:0] OFS_DSV   = 12'h134;
   localparam logic [11:0] OFS_IRQST = 12'h140;
   localparam logic [11:0] OFS_IRQMK = 12'h144;
   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int          CTL_EN_BIT  = 0;
   localparam int          CTL_STB_BIT = 1;
   localparam int          CTL_ADJ_LSB = 3;
   localparam int          CTL_CAL_LSB = 8;
   localparam logic [4:0]  ADJ_RST     = 5'h10;
   localparam logic [1:0]  DSV_RST     = 2'h0;
   localparam logic [31:0] UNLOCK_KEY  = 32'h1A2B_3C4D;
   localparam logic [7:0]  TRIM_MAX    = 8'hFF;
   // ****************************************
   // Interrupt event bits
   // ****************************************
   localparam int          EV_STB_RISE = 0;
   localparam int          EV_STB_FALL = 1;
   localparam int          EV_DSV_REJ  = 2;
   localparam int          EV_NUM      = 3;
endpackage

// File: rtl/rcvk_top.sv
// Module: 28 MHz RC oscillator trim control and key-guarded deep-sleep vcore select
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
// ****************************************
// Overview of operation
// RULE1 - Control register resets to 0x0000_XX80; calibration byte not set by reset.
// RULE2 - Factory calibration loads itself after power-on and is read-only to software.
// RULE3 - Trim driven to oscillator is calibration byte plus 5-bit adjust field.
// RULE4 - Software picks adjust so oscillator runs within one percent of 28 MHz.
// RULE5 - Stable flag bit 1 is read-only, set only while oscillator is stable.
// RULE6 - Bit 0 is software enable: 0 turns oscillator off, 1 on.
// RULE7 - Software writes reserved bits with their reset values.
// RULE8 - Unlock key register is write-only and always reads zero.
// RULE9 - Deep-sleep voltage writes accepted only after key 0x1A2B3C4D was written.
// RULE10 - Voltage select 00=1.0V, 01=0.9V, 10=0.8V, 11=1.2V in deep-sleep.
// RULE11 - Key and voltage registers accept 8, 16 and 32-bit accesses.
// RULE12 - Voltage writes without correct key, or wrong key values, leave it locked.
// ****************************************
module rcvk_top
(
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        nrst_in,
   // Wishbone slave
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [11:0] wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic      [31:0] wb_dat_out,
   output logic             wb_ack_out,
   // Oscillator and power unit
   input  wire logic [7:0]  factory_cal_in,
   input  wire logic        osc_ready_in,
   output logic             osc_en_out,
   output logic      [7:0]  osc_trim_out,
   output logic      [1:0]  deep_sleep_vcore_sel_out,
   // Interrupt
   output logic             irq_out
);
   // ****************************************
   // Bus decode
   // ****************************************
   logic        ack_r;
   logic        ack_nxt;
   logic [31:0] rdat_r;
   logic [31:0] rdat_nxt;
   logic        req;
   logic        wr;
   logic        hit_ctl;
   logic        hit_key;
   logic        hit_dsv;
   logic        hit_st;
   logic        hit_mk;
   logic [31:0] bmask;

   assign req     = wb_cyc_in & wb_stb_in;
   // Writes land at the edge where the master sees ack, as classic cycles expect
   assign wr      = req & wb_we_in & ack_r;
   assign hit_ctl = wb_adr_in[11:2] == rcvk_pkg::OFS_CTL[11:2];
   assign hit_key = wb_adr_in[11:2] == rcvk_pkg::OFS_KEY[11:2];
   assign hit_dsv = wb_adr_in[11:2] == rcvk_pkg::OFS_DSV[11:2];
   assign hit_st  = wb_adr_in[11:2] == rcvk_pkg::OFS_IRQST[11:2];
   assign hit_mk  = wb_adr_in[11:2] == rcvk_pkg::OFS_IRQMK[11:2];
   assign bmask   = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

   // ****************************************
   // Oscillator control state
   // ****************************************
   logic       sync1_r;
   logic       sync2_r;
   logic       stb_r;
   logic       en_r;
   logic       en_nxt;
   logic [4:0] adj_r;
   logic [4:0] adj_nxt;
   logic [7:0] cal_r;
   logic [7:0] cal_nxt;
   logic       cal_done_r;
   logic [8:0] sum;
   logic [7:0] trim_r;
   logic [7:0] trim_nxt;

   always_comb
   begin
      en_nxt   = en_r;
      adj_nxt  = adj_r;
      cal_nxt  = cal_r;
      if (!cal_done_r)
      begin
         cal_nxt = factory_cal_in; // RULE2
      end
      if (wr && hit_ctl && wb_sel_in[0])
      begin
         en_nxt  = wb_dat_in[rcvk_pkg::CTL_EN_BIT]; // RULE6
         adj_nxt = wb_dat_in[rcvk_pkg::CTL_ADJ_LSB +: 5]; // RULE3
      end
      // Saturate so an aggressive adjust never wraps to the slowest setting
      sum      = {1'b0, cal_r} + {4'h0, adj_r}; // RULE3
      trim_nxt = sum[8] ? rcvk_pkg::TRIM_MAX : sum[7:0];
   end

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         sync1_r    <= 1'b0;
         sync2_r    <= 1'b0;
         stb_r      <= 1'b0;
         en_r       <= 1'b0; // RULE1
         adj_r      <= rcvk_pkg::ADJ_RST; // RULE1
         cal_r      <= 8'h00;
         cal_done_r <= 1'b0;
         trim_r     <= 8'h00;
      end
      else
      begin
         sync1_r    <= osc_ready_in;
         sync2_r    <= sync1_r;
         stb_r      <= sync2_r; // RULE5
         en_r       <= en_nxt;
         adj_r      <= adj_nxt;
         cal_r      <= cal_nxt;
         cal_done_r <= 1'b1;
         trim_r     <= trim_nxt;
      end
   end

   assign osc_en_out   = en_r;
   assign osc_trim_out = trim_r;

   // ****************************************
   // Unlock key and deep-sleep voltage
   // ****************************************
   logic [31:0] key_r;
   logic [31:0] key_nxt;
   logic        unlock_r;
   logic        unlock_nxt;
   logic [1:0]  dsv_r;
   logic [1:0]  dsv_nxt;
   logic        dsv_rej;

   always_comb
   begin
      key_nxt    = key_r;
      unlock_nxt = unlock_r;
      dsv_nxt    = dsv_r;
      dsv_rej    = 1'b0;
      if (wr && hit_key)
      begin
         // Byte lanes merge so narrow writes can build the key
         key_nxt    = (key_r & ~bmask) | (wb_dat_in & bmask); // RULE11
         unlock_nxt = key_nxt == rcvk_pkg::UNLOCK_KEY; // RULE12
      end
      if (wr && hit_dsv)
      begin
         // One unlock buys one write; a second write needs the key again
         unlock_nxt = 1'b0;
         key_nxt    = 32'h0000_0000;
         if (unlock_r && wb_sel_in[0])
         begin
            dsv_nxt = wb_dat_in[1:0]; // RULE9
         end
         else if (!unlock_r)
         begin
            dsv_rej = 1'b1; // RULE12
         end
      end
   end

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         key_r    <= 32'h0000_0000;
         unlock_r <= 1'b0;
         dsv_r    <= rcvk_pkg::DSV_RST;
      end
      else
      begin
         key_r    <= key_nxt;
         unlock_r <= unlock_nxt;
         dsv_r    <= dsv_nxt;
      end
   end

   assign deep_sleep_vcore_sel_out = dsv_r; // RULE10

   // ****************************************
   // Interrupt status and mask
   // ****************************************
   localparam int NE = rcvk_pkg::EV_NUM;
   logic [NE-1:0] ev;
   logic [NE-1:0] st_r;
   logic [NE-1:0] st_nxt;
   logic [NE-1:0] mk_r;
   logic [NE-1:0] mk_nxt;

   always_comb
   begin
      ev                          = '0;
      ev[rcvk_pkg::EV_STB_RISE]   = sync2_r & ~stb_r;
      ev[rcvk_pkg::EV_STB_FALL]   = ~sync2_r & stb_r;
      ev[rcvk_pkg::EV_DSV_REJ]    = dsv_rej;
      st_nxt = st_r;
      mk_nxt = mk_r;
      if (wr && hit_st && wb_sel_in[0])
      begin
         st_nxt = st_r & ~wb_dat_in[NE-1:0];
      end
      if (wr && hit_mk && wb_sel_in[0])
      begin
         mk_nxt = wb_dat_in[NE-1:0];
      end
      // A new event outranks a clear in the same cycle
      st_nxt = st_nxt | ev;
   end

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         st_r <= '0;
         mk_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
         mk_r <= mk_nxt;
      end
   end

   assign irq_out = |(st_r & mk_r);

   // ****************************************
   // Read data and acknowledge
   // ****************************************
   always_comb
   begin
      ack_nxt  = req & ~ack_r;
      rdat_nxt = 32'h0000_0000;
      if (hit_ctl)
      begin
         rdat_nxt[rcvk_pkg::CTL_CAL_LSB +: 8] = cal_r; // RULE2
         rdat_nxt[rcvk_pkg::CTL_ADJ_LSB +: 5] = adj_r;
         rdat_nxt[rcvk_pkg::CTL_STB_BIT]      = stb_r; // RULE5
         rdat_nxt[rcvk_pkg::CTL_EN_BIT]       = en_r;
      end
      else if (hit_dsv)
      begin
         rdat_nxt[1:0] = dsv_r;
      end
      else if (hit_st)
      begin
         rdat_nxt[NE-1:0] = st_r;
      end
      else if (hit_mk)
      begin
         rdat_nxt[NE-1:0] = mk_r;
      end
      // Key and unmapped addresses answer zero
      rdat_nxt = rdat_nxt & bmask; // RULE8
   end

   always_ff @(posedge mclk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         ack_r  <= 1'b0;
         rdat_r <= 32'h0000_0000;
      end
      else
      begin
         ack_r  <= ack_nxt;
         rdat_r <= rdat_nxt;
      end
   end

   assign wb_ack_out = ack_r;
   assign wb_dat_out = rdat_r;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);

   chk_ctl_reset_val: assert property ($rose(cal_done_r) |-> adj_r == rcvk_pkg::ADJ_RST && !en_r) // RULE1
      else $error("control low byte not 0x80 after reset");
   chk_cal_read_only: assert property (cal_done_r && $past(cal_done_r) |-> $stable(cal_r)) // RULE2
      else $error("calibration byte changed after load");
   chk_trim_sum: assert property (cal_done_r && $stable(cal_r) && $stable(adj_r) && sum < 9'h100
                                  |=> osc_trim_out == $past(sum[7:0])) // RULE3
      else $error("trim is not calibration plus adjust");
   chk_stable_flag: assert property (req && !wb_we_in && hit_ctl && wb_sel_in[0] && !ack_r
                                     |=> wb_dat_out[1] == $past(stb_r)) // RULE5
      else $error("stable flag read wrong");
   chk_enable_write: assert property (wr && hit_ctl && wb_sel_in[0] |=> osc_en_out == $past(wb_dat_in[0])) // RULE6
      else $error("enable bit not applied");
   chk_key_reads_zero: assert property (ack_r && hit_key && !wb_we_in |-> wb_dat_out == 32'h0000_0000) // RULE8
      else $error("key register read nonzero");
   chk_dsv_locked: assert property (wr && hit_dsv && !unlock_r |=> $stable(dsv_r) ##1 (irq_out || !mk_r[2])) // RULE12
      else $error("locked voltage write took effect");
   chk_dsv_unlocked: assert property (wr && hit_dsv && unlock_r && wb_sel_in[0]
                                      |=> dsv_r == $past(wb_dat_in[1:0]) && !unlock_r) // RULE9
      else $error("unlocked voltage write lost");
   // Any voltage write, taken or not, must leave the guard armed again
   chk_dsv_relock: assert property (wr && hit_dsv |=> !unlock_r && key_r == 32'h0000_0000) // RULE12
      else $error("voltage write left the key armed");
   chk_key_byte: assert property (wr && hit_key && wb_sel_in == 4'h1 |=> key_r[31:8] == $past(key_r[31:8])) // RULE11
      else $error("byte key write touched other lanes");
   chk_ack_pulse: assert property (ack_r |=> !ack_r)
      else $error("ack held longer than one cycle");
endmodule // rcvk_top

// File: verification/rcvk_top_tb_top.sv
// Testbench: register, trim, key and interrupt checks of the RC trim and vcore block
`timescale 1ns/1ps
module rcvk_top_tb_top;
   logic        mclk_in;
   logic        nrst_in;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [11:0] adr;
   logic [3:0]  sel;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        ack;
   logic [7:0]  cal;
   logic        rdy;
   logic        en;
   logic [7:0]  trim;
   logic [1:0]  vsel;
   logic        irq;
   logic [15:0] rnd;
   logic [4:0]  adj;
   logic [8:0]  sum;
   logic [31:0] ctl;
   logic [31:0] exp_q[$];
   int          err_total;
   int          n_tests;

   rcvk_top i_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
      .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
      .factory_cal_in(cal), .osc_ready_in(rdy), .osc_en_out(en), .osc_trim_out(trim),
      .deep_sleep_vcore_sel_out(vsel), .irq_out(irq));

   initial
   begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   task automatic cmp(input logic [31:0] got, input logic [31:0] want);
      n_tests++;
      if (got !== want)
      begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask

   // For a read, d is the expected data; it goes to the queue for the monitor
   task automatic bus(input logic w, input logic [11:0] a, input logic [3:0] s, input logic [31:0] d);
      int n;
      n = 0;
      if (!w)
         exp_q.push_back(d);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= s;
      wdat <= d;
      do
      begin
         @(posedge mclk_in);
         n++;
      end
      while (ack !== 1'b1 && n < 50);
      if (n >= 50)
         err_total++;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge mclk_in);
   endtask

   task automatic settle;
      repeat (2) @(posedge mclk_in);
   endtask

   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Read data is only valid in the ack cycle, so it is judged there
   always @(posedge mclk_in)
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
         cmp(rdat, exp_q.pop_front());

   initial
   begin
      repeat (20000) @(posedge mclk_in);
      err_total++;
      summarize;
   end

   initial
   begin
      nrst_in = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 12'h000; sel = 4'h0;
      wdat = 32'h0000_0000; rdy = 1'b0; err_total = 0; n_tests = 0;
      rnd = 16'hD454;
      // High calibration byte so the reset adjust already saturates the trim
      cal = rnd[7:0] | 8'hE0;
      repeat (2) @(posedge mclk_in);
      nrst_in <= 1'b1;
      @(posedge mclk_in);
      bus(1'b0, rcvk_pkg::OFS_CTL, 4'hF, {16'h0000, cal, 8'h80});
      settle;
      cmp(en, 1'b0);
      sum = cal + 9'h010;
      cmp(trim, sum[8] ? 8'hFF : sum[7:0]);
      $display("test reset done");
      for (int k = 0; k < 6; k++)
      begin
         rnd = lfsr(rnd);
         adj = (k == 5) ? 5'h1F : rnd[4:0] & 5'h07;
         ctl = {16'h0000, cal, adj, 2'b00, rnd[8]};
         bus(1'b1, rcvk_pkg::OFS_CTL, 4'hF, {16'h0000, ~cal, adj, 2'b00, rnd[8]});
         bus(1'b0, rcvk_pkg::OFS_CTL, 4'hF, ctl);
         settle;
         sum = cal + adj;
         cmp(en, rnd[8]);
         cmp(trim, sum[8] ? 8'hFF : sum[7:0]);
      end
      $display("test trim done");
      rdy <= 1'b1;
      repeat (6) @(posedge mclk_in);
      bus(1'b0, rcvk_pkg::OFS_CTL, 4'hF, ctl | 32'h0000_0002);
      rdy <= 1'b0;
      repeat (6) @(posedge mclk_in);
      bus(1'b0, rcvk_pkg::OFS_CTL, 4'hF, ctl);
      $display("test stable done");
      bus(1'b1, rcvk_pkg::OFS_DSV, 4'hF, 32'h0000_0001);
      bus(1'b1, rcvk_pkg::OFS_KEY, 4'hF, rcvk_pkg::UNLOCK_KEY ^ 32'h0000_0001);
      bus(1'b1, rcvk_pkg::OFS_DSV, 4'hF, 32'h0000_0002);
      bus(1'b0, rcvk_pkg::OFS_DSV, 4'hF, 32'h0000_0000);
      for (int k = 0; k < 4; k++)
      begin
         bus(1'b1, rcvk_pkg::OFS_KEY, 4'hF, rcvk_pkg::UNLOCK_KEY);
         bus(1'b0, rcvk_pkg::OFS_KEY, 4'hF, 32'h0000_0000);
         bus(1'b1, rcvk_pkg::OFS_DSV, 4'hF, 32'(3 - k));
         settle;
         cmp(vsel, 32'(3 - k));
      end
      bus(1'b1, rcvk_pkg::OFS_DSV, 4'hF, 32'h0000_0001);
      settle;
      cmp(vsel, 2'b00);
      for (int k = 0; k < 4; k++)
         bus(1'b1, rcvk_pkg::OFS_KEY, 4'(1 << k), rcvk_pkg::UNLOCK_KEY);
      bus(1'b1, rcvk_pkg::OFS_DSV, 4'h1, 32'h0000_0002);
      settle;
      cmp(vsel, 2'b10);
      bus(1'b1, rcvk_pkg::OFS_KEY, 4'h3, rcvk_pkg::UNLOCK_KEY);
      bus(1'b1, rcvk_pkg::OFS_KEY, 4'hC, rcvk_pkg::UNLOCK_KEY);
      bus(1'b1, rcvk_pkg::OFS_DSV, 4'h3, 32'h0000_0001);
      bus(1'b0, rcvk_pkg::OFS_DSV, 4'h1, 32'h0000_0001);
      // A write without the lane of the field changes nothing but still spends the key
      bus(1'b1, rcvk_pkg::OFS_KEY, 4'hF, rcvk_pkg::UNLOCK_KEY);
      bus(1'b1, rcvk_pkg::OFS_DSV, 4'h2, 32'h0000_0002);
      bus(1'b1, rcvk_pkg::OFS_DSV, 4'hF, 32'h0000_0003);
      bus(1'b0, rcvk_pkg::OFS_DSV, 4'hF, 32'h0000_0001);
      $display("test key done");
      bus(1'b1, 12'h200, 4'hF, 32'hFFFF_FFFF);
      bus(1'b0, 12'h200, 4'hF, 32'h0000_0000);
      bus(1'b0, rcvk_pkg::OFS_IRQST, 4'hF, 32'h0000_0007);
      cmp(irq, 1'b0);
      bus(1'b1, rcvk_pkg::OFS_IRQMK, 4'hF, 32'h0000_0004);
      settle;
      cmp(irq, 1'b1);
      bus(1'b1, rcvk_pkg::OFS_IRQST, 4'hF, 32'h0000_0004);
      settle;
      cmp(irq, 1'b0);
      bus(1'b0, rcvk_pkg::OFS_IRQST, 4'hF, 32'h0000_0003);
      bus(1'b1, rcvk_pkg::OFS_IRQMK, 4'hF, 32'h0000_0001);
      settle;
      cmp(irq, 1'b1);
      bus(1'b1, rcvk_pkg::OFS_IRQST, 4'hF, 32'h0000_0003);
      bus(1'b0, rcvk_pkg::OFS_IRQST, 4'hF, 32'h0000_0000);
      cmp(irq, 1'b0);
      $display("test irq done");
      summarize;
   end
endmodule // rcvk_top_tb_top
